//--- rtl/usp_defines.svh
`ifndef USP_DEFINES_SVH
`define USP_DEFINES_SVH

// Register offsets
`define USP_OFF_CTRL_HIGH 8'hFC
`define USP_OFF_CTRL_LOW  8'hFD
`define USP_OFF_DATA      8'hFE
`define USP_OFF_BAUD      8'hFF

// Reset values
`define USP_RST_BYTE      8'h00
`define USP_RST_MODE      2'h0
`define USP_RST_CLKSEL    2'h0

// Control high field positions
`define USP_CH_MODE_HI    7
`define USP_CH_MODE_LO    6
`define USP_CH_MCE        5
`define USP_CH_RXEN       4
`define USP_CH_TB8        3
`define USP_CH_RB8        2

// Control low field positions
`define USP_CL_UTP        7
`define USP_CL_TX_PARITY_SENSE       6
`define USP_CL_RX_PARITY_SENSE       5
`define USP_CL_RX_PARITY_ERROR_FLAG      4
`define USP_CL_CLK_HI     3
`define USP_CL_CLK_LO     2

// Prescaler limits (count of clock cycles per source tick minus one)
`define USP_PRE_DIV8      3'h7
`define USP_PRE_DIV4      3'h3
`define USP_PRE_DIV2      3'h1
`define USP_PRE_DIV1      3'h0

// Bit timing in 16x ticks
`define USP_TICK_ZERO     4'h0
`define USP_TICK_ONE      4'h1
`define USP_TICK_MID      4'h7
`define USP_TICK_LAST     4'hF
`define USP_BIT_ZERO      3'h0
`define USP_BIT_ONE       3'h1
`define USP_BIT_LAST      3'h7

`endif

//--- rtl/usp_pkg.sv
`default_nettype none
package usp_pkg;

  typedef enum logic [1:0] {
    USP_MODE_SYNC  = 2'h0,
    USP_MODE_ASY8  = 2'h1,
    USP_MODE_ASY9F = 2'h2,
    USP_MODE_ASY9V = 2'h3
  } usp_mode_t;

  // Gray codes along idle, start, data, ninth, stop
  typedef enum logic [2:0] {
    USP_ST_IDLE  = 3'h0,
    USP_ST_START = 3'h1,
    USP_ST_DATA  = 3'h3,
    USP_ST_NINTH = 3'h2,
    USP_ST_STOP  = 3'h6
  } usp_state_t;

endpackage
`default_nettype wire

//--- rtl/usp_divider.sv
`include "usp_defines.svh"
`default_nettype none
module usp_divider #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         en,
  input  wire logic [W-1:0] limit,
  output logic              tick
);

  logic [W-1:0] cnt_r;

  assign tick = ce && en && (cnt_r >= limit);

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (ce && en) begin
      if (cnt_r >= limit) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + W'(1);
      end
    end
  end

endmodule
`default_nettype wire

//--- rtl/usp_top.sv
// Functional notes
// - Two-bit mode field: sync, 8-bit async, 9-bit at clock/16, 9-bit programmable.
// - Sync mode is clock master, half-duplex, rate source/(16*(divisor+1)).
// - 8-bit async mode uses programmable rate and no parity bit.
// - Programmable rates use the prescaled source clock, not raw clock.
// - Source clock select: 00 /8, 01 /4, 10 /2, 11 /1.
// - 9-bit with filter: receive request only when ninth bit is 1.
// - 8-bit async with filter: receive request only on valid stop bit.
// - Ninth tx bit from control, ninth rx bit captured; unused outside 9-bit.
// - Async reception only while receive enable is 1; sync receive needs it to start, then ignores it.
// - Parity autogen makes ninth bit parity; sense 0 even, 1 odd.
// - 9-bit receive checks ninth bit as parity; sense 0 even, 1 odd.
// - Parity mismatch sets parity error flag; it holds its value until software writes control low.
// - Separate tx and rx buffers at one address: write tx, read rx.
// - Sync mode: data on rx pin, shift clock on tx pin, 8 bits LSB first.
// - 8-bit async frame: start 0, eight data LSB first, stop 1.
// - 9-bit frame: start, eight data, ninth bit, stop; stop ignored on receive.
// - 9-bit receive writes ninth bit to status at frame end.
//
// The address-and-strobe port is this design's own decision.
`include "usp_defines.svh"
`default_nettype none
module usp_top
  import usp_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       rxd_in,
  output logic            rxd_out,
  output logic            rxd_oe,
  output logic            txd,
  output logic            tx_irq,
  output logic            rx_irq
);

  usp_mode_t  mode_r;
  logic       mce_r;
  logic       rxen_r;
  logic       tb8_r;
  logic       rb8_r;
  logic       utp_r;
  logic       tx_parity_sense_r;
  logic       rx_parity_sense_r;
  logic       rx_parity_error_flag_r;
  logic [1:0] clksel_r;
  logic [7:0] baud_r;
  logic [7:0] txbuf_r;
  logic [7:0] rxbuf_r;
  logic [7:0] rdata_r;

  logic       wr_high;
  logic       wr_low;
  logic       wr_data;
  logic       wr_baud;

  assign wr_high = wr && (addr == `USP_OFF_CTRL_HIGH);
  assign wr_low  = wr && (addr == `USP_OFF_CTRL_LOW);
  assign wr_data = wr && (addr == `USP_OFF_DATA);
  assign wr_baud = wr && (addr == `USP_OFF_BAUD);

  // Clock generation
  logic [2:0] pre_limit;
  logic       src_tick;
  logic       baud_tick;
  logic       tick16;
  logic       nine;

  always_comb begin
    case (clksel_r)
      2'h0:    pre_limit = `USP_PRE_DIV8;
      2'h1:    pre_limit = `USP_PRE_DIV4;
      2'h2:    pre_limit = `USP_PRE_DIV2;
      default: pre_limit = `USP_PRE_DIV1;
    endcase
  end

  usp_divider #(.W(3)) u_prescale (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .en    (1'b1),
    .limit (pre_limit),
    .tick  (src_tick)
  );

  usp_divider #(.W(8)) u_baud (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .en    (src_tick),
    .limit (baud_r),
    .tick  (baud_tick)
  );

  // Fixed-rate 9-bit mode counts raw clock; others use the divided source
  assign tick16 = (mode_r == USP_MODE_ASY9F) ? ce : baud_tick;
  assign nine   = mode_r[1];

  // Transmit and synchronous engine
  usp_state_t tx_state_r;
  logic [3:0] tx_phase_r;
  logic [2:0] tx_cnt_r;
  logic [7:0] tx_sh_r;
  logic       tx_ninth_r;
  logic       sync_rx_r;
  logic       tx_bit_end;
  logic       tx_start;
  logic       sync_rx_go;
  logic       tx_done;
  logic       sync_rx_done;
  logic       txd_r;
  logic       rxd_oe_r;

  assign tx_bit_end = tick16 && (tx_phase_r == `USP_TICK_LAST);
  assign tx_start   = wr_data && (tx_state_r == USP_ST_IDLE);
  assign sync_rx_go = wr_high && wdata[`USP_CH_RXEN] && (tx_state_r == USP_ST_IDLE)
                      && (wdata[`USP_CH_MODE_HI:`USP_CH_MODE_LO] == USP_MODE_SYNC);
  assign tx_done      = ce && tx_bit_end && !sync_rx_r && ((tx_state_r == USP_ST_STOP)
                        || (mode_r == USP_MODE_SYNC && tx_state_r == USP_ST_DATA
                        && tx_cnt_r == `USP_BIT_LAST));
  assign sync_rx_done = ce && tx_bit_end && sync_rx_r && tx_state_r == USP_ST_DATA
                        && tx_cnt_r == `USP_BIT_LAST;

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_state_r <= USP_ST_IDLE;
      tx_phase_r <= `USP_TICK_ZERO;
      tx_cnt_r   <= `USP_BIT_ZERO;
      tx_sh_r    <= `USP_RST_BYTE;
      tx_ninth_r <= 1'b0;
      sync_rx_r  <= 1'b0;
    end else if (ce) begin
      if (tx_state_r != USP_ST_IDLE && tick16) begin
        tx_phase_r <= tx_phase_r + `USP_TICK_ONE;
      end
      case (tx_state_r)
        USP_ST_IDLE: begin
          tx_phase_r <= `USP_TICK_ZERO;
          tx_cnt_r   <= `USP_BIT_ZERO;
          if (tx_start) begin
            tx_sh_r    <= wdata;
            sync_rx_r  <= 1'b0;
            tx_ninth_r <= utp_r ? ((^wdata) ^ tx_parity_sense_r) : tb8_r;
            tx_state_r <= (mode_r == USP_MODE_SYNC) ? USP_ST_DATA : USP_ST_START;
          end else if (sync_rx_go) begin
            sync_rx_r  <= 1'b1;
            tx_state_r <= USP_ST_DATA;
          end
        end
        USP_ST_START: begin
          if (tx_bit_end) begin
            tx_state_r <= USP_ST_DATA;
          end
        end
        USP_ST_DATA: begin
          if (tx_bit_end) begin
            tx_cnt_r <= tx_cnt_r + `USP_BIT_ONE;
            tx_sh_r  <= {sync_rx_r ? rxd_in : 1'b0, tx_sh_r[7:1]};
            if (tx_cnt_r == `USP_BIT_LAST) begin
              if (mode_r == USP_MODE_SYNC) begin
                tx_state_r <= USP_ST_IDLE;
              end else begin
                tx_state_r <= nine ? USP_ST_NINTH : USP_ST_STOP;
              end
            end
          end
        end
        USP_ST_NINTH: begin
          if (tx_bit_end) begin
            tx_state_r <= USP_ST_STOP;
          end
        end
        USP_ST_STOP: begin
          if (tx_bit_end) begin
            tx_state_r <= USP_ST_IDLE;
          end
        end
        default: begin
          tx_state_r <= USP_ST_IDLE;
        end
      endcase
    end
  end

  // Pin drivers
  always_ff @(posedge clock) begin
    if (rst) begin
      txd_r    <= 1'b1;
      rxd_oe_r <= 1'b0;
    end else if (ce) begin
      rxd_oe_r <= (mode_r == USP_MODE_SYNC) && (tx_state_r == USP_ST_DATA) && !sync_rx_r;
      if (mode_r == USP_MODE_SYNC) begin
        txd_r <= (tx_state_r == USP_ST_DATA) ? tx_phase_r[3] : 1'b1;
      end else begin
        case (tx_state_r)
          USP_ST_START: txd_r <= 1'b0;
          USP_ST_DATA:  txd_r <= tx_sh_r[0];
          USP_ST_NINTH: txd_r <= tx_ninth_r;
          default:      txd_r <= 1'b1;
        endcase
      end
    end
  end

  assign txd     = txd_r;
  assign rxd_out = tx_sh_r[0];
  assign rxd_oe  = rxd_oe_r;

  // Asynchronous receiver
  usp_state_t rx_state_r;
  logic [3:0] rx_phase_r;
  logic [2:0] rx_cnt_r;
  logic [7:0] rx_sh_r;
  logic       rx_ninth_r;
  logic       rx_mid;
  logic       rx_done;
  logic       rx_accept;
  logic       rx_perr;

  assign rx_mid    = tick16 && (rx_phase_r == `USP_TICK_MID);
  assign rx_done   = ce && rx_mid && (rx_state_r == USP_ST_STOP) && rxen_r;
  assign rx_accept = !mce_r || (nine ? rx_ninth_r : rxd_in);
  assign rx_perr   = nine && (((^rx_sh_r) ^ rx_ninth_r) != rx_parity_sense_r);

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_state_r <= USP_ST_IDLE;
      rx_phase_r <= `USP_TICK_ZERO;
      rx_cnt_r   <= `USP_BIT_ZERO;
      rx_sh_r    <= `USP_RST_BYTE;
      rx_ninth_r <= 1'b0;
    end else if (ce) begin
      if (tick16) begin
        rx_phase_r <= rx_phase_r + `USP_TICK_ONE;
      end
      if (!rxen_r || mode_r == USP_MODE_SYNC) begin
        rx_state_r <= USP_ST_IDLE;
      end else begin
        case (rx_state_r)
          USP_ST_IDLE: begin
            rx_cnt_r <= `USP_BIT_ZERO;
            if (tick16 && !rxd_in) begin
              rx_phase_r <= `USP_TICK_ONE;
              rx_state_r <= USP_ST_START;
            end
          end
          USP_ST_START: begin
            if (rx_mid) begin
              rx_state_r <= rxd_in ? USP_ST_IDLE : USP_ST_DATA;
            end
          end
          USP_ST_DATA: begin
            if (rx_mid) begin
              rx_sh_r  <= {rxd_in, rx_sh_r[7:1]};
              rx_cnt_r <= rx_cnt_r + `USP_BIT_ONE;
              if (rx_cnt_r == `USP_BIT_LAST) begin
                rx_state_r <= nine ? USP_ST_NINTH : USP_ST_STOP;
              end
            end
          end
          USP_ST_NINTH: begin
            if (rx_mid) begin
              rx_ninth_r <= rxd_in;
              rx_state_r <= USP_ST_STOP;
            end
          end
          USP_ST_STOP: begin
            if (rx_mid) begin
              rx_state_r <= USP_ST_IDLE;
            end
          end
          default: begin
            rx_state_r <= USP_ST_IDLE;
          end
        endcase
      end
    end
  end

  // Completion requests
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end else if (ce) begin
      tx_irq <= tx_done;
      rx_irq <= sync_rx_done || (rx_done && rx_accept);
    end else begin
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end
  end

  // Data buffers
  always_ff @(posedge clock) begin
    if (rst) begin
      txbuf_r <= `USP_RST_BYTE;
      rxbuf_r <= `USP_RST_BYTE;
    end else if (ce) begin
      if (wr_data) begin
        txbuf_r <= wdata;
      end
      if (sync_rx_done) begin
        rxbuf_r <= {rxd_in, tx_sh_r[7:1]};
      end else if (rx_done) begin
        rxbuf_r <= rx_sh_r;
      end
    end
  end

  // Control registers
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_r   <= usp_mode_t'(`USP_RST_MODE);
      mce_r    <= 1'b0;
      rxen_r   <= 1'b0;
      tb8_r    <= 1'b0;
      utp_r    <= 1'b0;
      tx_parity_sense_r   <= 1'b0;
      rx_parity_sense_r   <= 1'b0;
      clksel_r <= `USP_RST_CLKSEL;
      baud_r   <= `USP_RST_BYTE;
    end else if (ce) begin
      if (wr_high) begin
        mode_r <= usp_mode_t'(wdata[`USP_CH_MODE_HI:`USP_CH_MODE_LO]);
        mce_r  <= wdata[`USP_CH_MCE];
        rxen_r <= wdata[`USP_CH_RXEN];
        tb8_r  <= wdata[`USP_CH_TB8];
      end
      if (wr_low) begin
        utp_r    <= wdata[`USP_CL_UTP];
        tx_parity_sense_r   <= wdata[`USP_CL_TX_PARITY_SENSE];
        rx_parity_sense_r   <= wdata[`USP_CL_RX_PARITY_SENSE];
        clksel_r <= wdata[`USP_CL_CLK_HI:`USP_CL_CLK_LO];
      end
      if (wr_baud) begin
        baud_r <= wdata;
      end
    end
  end

  // Status bits: hardware capture wins over a same-cycle write
  always_ff @(posedge clock) begin
    if (rst) begin
      rb8_r   <= 1'b0;
      rx_parity_error_flag_r <= 1'b0;
    end else if (ce) begin
      if (wr_high) begin
        rb8_r <= wdata[`USP_CH_RB8];
      end
      if (wr_low) begin
        rx_parity_error_flag_r <= wdata[`USP_CL_RX_PARITY_ERROR_FLAG];
      end
      if (rx_done && nine) begin
        rb8_r <= rx_ninth_r;
      end
      if (rx_done && rx_perr) begin
        rx_parity_error_flag_r <= 1'b1;
      end
    end
  end

  // Read port
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_r <= `USP_RST_BYTE;
    end else if (ce) begin
      rdata_r <= `USP_RST_BYTE;
      if (rd) begin
        case (addr)
          `USP_OFF_CTRL_HIGH: rdata_r <= {mode_r, mce_r, rxen_r, tb8_r, rb8_r, 2'h0};
          `USP_OFF_CTRL_LOW:  rdata_r <= {utp_r, tx_parity_sense_r, rx_parity_sense_r, rx_parity_error_flag_r, clksel_r, 2'h0};
          `USP_OFF_DATA:      rdata_r <= rxbuf_r;
          `USP_OFF_BAUD:      rdata_r <= baud_r;
          default:            rdata_r <= `USP_RST_BYTE;
        endcase
      end
    end
  end

  assign rdata = rdata_r;

endmodule
`default_nettype wire

//--- tb/usp_asserts.sv
`default_nettype none
module usp_asserts (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       rxd_oe,
  input wire logic       txd,
  input wire logic       tx_irq,
  input wire logic       rx_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctrl_hi_r;
  logic [7:0] ctrl_lo_r;
  logic [7:0] baud_r;
  logic       busy_r;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  // Shadow of software-written fields
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_hi_r <= 8'h00;
      ctrl_lo_r <= 8'h00;
      baud_r    <= 8'h00;
    end else if (ce && wr) begin
      case (addr)
        8'hFC: ctrl_hi_r <= wdata;
        8'hFD: ctrl_lo_r <= wdata;
        8'hFF: baud_r <= wdata;
        default: ;
      endcase
    end
  end
  // Transmitter busy from start write to completion pulse
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_r <= 1'b0;
    end else if (ce && wr && addr == 8'hFE) begin
      busy_r <= 1'b1;
    end else if (tx_irq) begin
      busy_r <= 1'b0;
    end
  end
  reset_idle_a: assert property ($fell(rst) |-> txd && !rxd_oe && !tx_irq && !rx_irq && rdata == 8'h00)
    else $error("outputs not idle after reset");
  rdata_zero_a: assert property ((!rd && ce) |=> rdata == 8'h00)
    else $error("read data not cleared");
  ctrl_read_a: assert property ((rd && ce && addr == 8'hFC) |=> rdata[7:3] == ctrl_hi_r[7:3])
    else $error("control high readback wrong");
  clksel_read_a: assert property ((rd && ce && addr == 8'hFD) |=> {rdata[7:5], rdata[3:2]} == {ctrl_lo_r[7:5], ctrl_lo_r[3:2]})
    else $error("control low readback wrong");
  baud_read_a: assert property ((rd && ce && addr == 8'hFF) |=> rdata == baud_r)
    else $error("divisor readback wrong");
  tx_start_a: assert property ((wr && ce && addr == 8'hFE && !busy_r && ctrl_hi_r[7:6] != 2'h0) |-> ##3 !txd)
    else $error("start bit missing");
  tx_idle_a: assert property ((ctrl_hi_r[7:6] != 2'h0 && !busy_r && !$past(busy_r)) |-> txd)
    else $error("line not idle high");
  tx_pulse_a: assert property (tx_irq |=> !tx_irq)
    else $error("tx request longer than one cycle");
  rx_pulse_a: assert property (rx_irq |=> !rx_irq)
    else $error("rx request longer than one cycle");
  tx_done_a: assert property (tx_irq |-> busy_r)
    else $error("tx request without transfer");
  rx_enable_a: assert property (rx_irq |-> ctrl_hi_r[4])
    else $error("rx request while receive disabled");
  oe_async_a: assert property ((ctrl_hi_r[7:6] != 2'h0) |-> !rxd_oe)
    else $error("rx pin driven in async mode");
endmodule
bind usp_top usp_asserts u_usp_asserts (.clock(clock), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .rxd_oe(rxd_oe), .txd(txd), .tx_irq(tx_irq), .rx_irq(rx_irq));
`default_nettype wire

//--- tb/usp_partner.sv
`default_nettype none
module usp_partner (
  input  wire logic        clock,
  input  wire logic        txd,
  input  wire logic        rxd,
  output logic             line,
  input  wire logic [15:0] bit_clks,
  input  wire logic [3:0]  nbits
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] got;
  logic       got_stop;
  logic [7:0] sgot;
  int         n_got;
  initial begin
    line = 1'b1;
    n_got = 0;
  end
  // Start 0, data LSB first, then stop level
  task automatic send(input logic [8:0] d, input int nb, input logic stop_v);
    line <= 1'b0;
    repeat (bit_clks) @(posedge clock);
    for (int i = 0; i < nb; i++) begin
      line <= d[i];
      repeat (bit_clks) @(posedge clock);
    end
    line <= stop_v;
    repeat (bit_clks) @(posedge clock);
    line <= 1'b1;
  endtask
  // Decode sent frames at mid-bit
  always @(negedge txd) begin
    repeat (bit_clks / 2) @(posedge clock);
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_clks) @(posedge clock);
      got[i] = txd;
    end
    repeat (bit_clks) @(posedge clock);
    got_stop = txd;
    n_got++;
  end
  // Sync mode: take the data pin on each rising shift clock
  always @(posedge txd) begin
    sgot <= {rxd, sgot[7:1]};
  end
endmodule
`default_nettype wire

//--- tb/usp_top_tb.sv
`default_nettype none
`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; $display("ERROR %0t: %h != %h", $time, g, e); end end
module usp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst, ce, wr, rd, rxd_in, rxd_out, rxd_oe, txd, tx_irq, rx_irq, pline;
  logic [7:0]  addr, wdata, rdata, rv, d;
  logic [15:0] bit_clks;
  logic [3:0]  nbits;
  int          fails = 0, n_compared = 0, n_tx = 0, n_rx = 0;
  logic [7:0]  cfg_hi[5] = '{8'h48, 8'h48, 8'h48, 8'hC8, 8'h88};
  logic [7:0]  cfg_lo[5] = '{8'h0C, 8'h00, 8'h04, 8'h08, 8'h00};
  logic [7:0]  cfg_dv[5] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h05};
  int          cfg_clks[5] = '{16, 128, 128, 96, 16};
  usp_top u_usp_top (.clock(clock), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd), .tx_irq(tx_irq), .rx_irq(rx_irq));
  usp_partner u_usp_partner (.clock(clock), .txd(txd), .rxd(rxd_in), .line(pline), .bit_clks(bit_clks),
    .nbits(nbits));
  assign rxd_in = (rxd_oe === 1'b1) ? rxd_out : pline;
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    if (tx_irq === 1'b1)
      n_tx++;
    if (rx_irq === 1'b1)
      n_rx++;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 rv = rdata;
    `CHECK(rv & m, e);
  endtask
  task automatic tx_frame(input logic [7:0] v, input logic [8:0] e);
    int t0;
    logic [8:0] m;
    t0 = n_tx;
    m = (nbits == 4'd9) ? 9'h1FF : 9'h0FF;
    wr_reg(8'hFE, v);
    for (int w = 0; w < 4000 && n_tx == t0; w++)
      @(posedge clock);
    `CHECK(n_tx - t0, 1);
    `CHECK(u_usp_partner.got & m, e & m);
    `CHECK(u_usp_partner.got_stop, 1'b1);
  endtask
  task automatic rx_frame(input logic [8:0] v, input int nb, input logic sv, input int e);
    int r0;
    r0 = n_rx;
    @(posedge clock);
    u_usp_partner.send(v, nb, sv);
    repeat (4) @(posedge clock);
    `CHECK(n_rx - r0, e);
  endtask
  // Sync transfer: transmit by buffer write, or receive started by control write
  task automatic sync_frame(input logic [7:0] v, input logic to_rx);
    int t0, r0;
    t0 = n_tx;
    r0 = n_rx;
    fork
      if (to_rx)
        wr_reg(8'hFC, 8'h10);
      else
        wr_reg(8'hFE, v);
      if (to_rx)
        u_usp_partner.send({1'b1, v}, 8, 1'b1);
    join
    repeat (150) @(posedge clock);
    `CHECK(n_tx - t0, to_rx ? 0 : 1);
    `CHECK(n_rx - r0, to_rx ? 1 : 0);
    if (to_rx)
      chk_reg(8'hFE, 8'hFF, v);
    else
      `CHECK(u_usp_partner.sgot, v);
  endtask
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    bit_clks = 16'd16;
    nbits = 4'd9;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    chk_reg(8'hFC, 8'hFF, 8'h00);
    chk_reg(8'hFD, 8'hFF, 8'h00);
    chk_reg(8'hFF, 8'hFF, 8'h00);
    @(posedge clock);
    ce <= 1'b0;
    wr_reg(8'hFF, 8'h33);
    ce <= 1'b1;
    chk_reg(8'hFF, 8'hFF, 8'h00);
    wr_reg(8'h10, 8'h5A);
    chk_reg(8'h10, 8'hFF, 8'h00);
    chk_reg(8'hFC, 8'hFF, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 5; k++) begin
      wr_reg(8'hFC, cfg_hi[k]);
      wr_reg(8'hFD, cfg_lo[k]);
      wr_reg(8'hFF, cfg_dv[k]);
      bit_clks = cfg_clks[k][15:0];
      nbits = cfg_hi[k][7] ? 4'd9 : 4'd8;
      tx_frame(8'h96 + 8'(k), {1'b1, 8'h96 + 8'(k)});
    end
    $display("test rates done");
    wr_reg(8'hFC, 8'hC8);
    wr_reg(8'hFF, 8'h00);
    bit_clks = 16'd16;
    for (int k = 0; k < 3; k++) begin
      wr_reg(8'hFD, (k != 0) ? 8'hCC : 8'h8C);
      d = (k == 1) ? 8'h07 : 8'h03;
      tx_frame(d, {(^d) ^ (k != 0), d});
    end
    $display("test parity gen done");
    wr_reg(8'hFD, 8'h0C);
    wr_reg(8'hFC, 8'hD0);
    rx_frame({1'b0, 8'h3C}, 9, 1'b1, 1);
    chk_reg(8'hFE, 8'hFF, 8'h3C);
    chk_reg(8'hFC, 8'h04, 8'h00);
    chk_reg(8'hFD, 8'h10, 8'h00);
    tx_frame(8'h81, 9'h081);
    chk_reg(8'hFE, 8'hFF, 8'h3C);
    rx_frame({1'b1, 8'h3C}, 9, 1'b1, 1);
    chk_reg(8'hFC, 8'h04, 8'h04);
    chk_reg(8'hFD, 8'h10, 8'h10);
    wr_reg(8'hFD, 8'h2C);
    chk_reg(8'hFD, 8'h10, 8'h00);
    rx_frame({1'b1, 8'h3C}, 9, 1'b1, 1);
    chk_reg(8'hFD, 8'h10, 8'h00);
    $display("test receive done");
    wr_reg(8'hFC, 8'hF0);
    rx_frame({1'b0, 8'h11}, 9, 1'b1, 0);
    chk_reg(8'hFE, 8'hFF, 8'h11);
    rx_frame({1'b1, 8'h22}, 9, 1'b1, 1);
    wr_reg(8'hFC, 8'hC0);
    rx_frame({1'b1, 8'h55}, 9, 1'b1, 0);
    chk_reg(8'hFE, 8'hFF, 8'h22);
    wr_reg(8'hFC, 8'h70);
    rx_frame({1'b0, 8'h66}, 8, 1'b1, 1);
    chk_reg(8'hFE, 8'hFF, 8'h66);
    rx_frame({1'b0, 8'h77}, 8, 1'b0, 0);
    $display("test filter done");
    wr_reg(8'hFC, 8'h00);
    sync_frame(8'hA5, 1'b0);
    sync_frame(8'h4B, 1'b1);
    $display("test sync done");
    finish_test();
  end
endmodule
`default_nettype wire
